// >>> common/gamma_dac_pkg.sv
// Constants for the gamma reference DAC latch control block.
// Assumes a two-wire bus master on the far side and one 100 MHz system clock.
package gamma_dac_pkg;

    // ========================================================================
    // Channel bank
    localparam int NUM_GAMMA = 18;
    localparam int NUM_COMMON = 2;
    localparam int NUM_CH = NUM_GAMMA + NUM_COMMON;
    localparam int CODE_W = 10;
    localparam int CODE_SPAN = 1024;
    localparam logic [9:0] MIDPOINT_CODE = 10'h200;
    // Common-voltage channels sit after the gamma channels
    localparam logic [4:0] FIRST_COMMON_CH = 5'h12;

    // ========================================================================
    // Two-wire bus framing
    localparam int BYTE_BITS = 8;
    localparam logic [3:0] ACK_SLOT = 4'h8;
    localparam logic [7:0] DEV_ADDR_BYTE = 8'h74;
    localparam logic [7:0] GC_ADDR_BYTE = 8'h00;
    localparam logic [7:0] GC_RESET_BYTE = 8'h06;

    // ========================================================================
    // Channel address byte fields
    localparam int CMD_MSB = 7;
    localparam int CMD_LSB = 5;
    localparam int CH_MSB = 4;
    localparam logic [2:0] CMD_WRITE = 3'h0;
    localparam logic [2:0] CMD_RESET_ALL = 3'h4;
    localparam logic [2:0] CMD_RESET_ONE = 3'h2;

    // ========================================================================
    // Data word fields
    localparam int SW_UPDATE_BIT = 15;

    // ========================================================================
    // Receive sequencer states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_GC_DATA,
        ST_POINTER,
        ST_DATA_HI,
        ST_DATA_LO,
        ST_IGNORE
    } rx_state_t;

endpackage

// >>> logic/gamma_dac_latch_control.sv
// Two-wire slave and double-register control for 20 ten-bit DAC channels.
// Assumes bus clock, bus data and latch pin arrive asynchronously and are
// sampled by clock; the bus data line is open drain, resolved outside.
`timescale 1ns/10ps

module gamma_dac_latch_control (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic enable,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic output_latch_pin,
    output logic [gamma_dac_pkg::NUM_CH-1:0][gamma_dac_pkg::CODE_W-1:0] dac_code
);

    // ========================================================================
    // Helper decoding
    function automatic logic chan_valid(input logic [7:0] b);
        chan_valid = (b[gamma_dac_pkg::CH_MSB:0] < 5'(gamma_dac_pkg::NUM_CH));
    endfunction

    function automatic logic [2:0] cmd_field(input logic [7:0] b);
        cmd_field = b[gamma_dac_pkg::CMD_MSB:gamma_dac_pkg::CMD_LSB];
    endfunction

    // ========================================================================
    // Input synchronisers
    logic [1:0] scl_sync_q;
    logic [1:0] sda_sync_q;
    logic [1:0] latch_sync_q;
    logic scl_prev_q;
    logic sda_prev_q;
    logic latch_prev_q;

    // Edge detectors start at the idle pin levels so no false edge follows reset
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            scl_sync_q <= 2'h3;
            sda_sync_q <= 2'h3;
            latch_sync_q <= 2'h0;
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
            latch_prev_q <= 1'b0;
        end else if (enable) begin
            scl_sync_q <= {scl_sync_q[0], scl_in};
            sda_sync_q <= {sda_sync_q[0], sda_in};
            latch_sync_q <= {latch_sync_q[0], output_latch_pin};
            scl_prev_q <= scl_sync_q[1];
            sda_prev_q <= sda_sync_q[1];
            latch_prev_q <= latch_sync_q[1];
        end
    end

    logic scl_s;
    logic sda_s;
    logic latch_s;
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    logic latch_fall;

    assign scl_s = scl_sync_q[1];
    assign sda_s = sda_sync_q[1];
    assign latch_s = latch_sync_q[1];
    assign scl_rise = scl_s && !scl_prev_q;
    assign scl_fall = !scl_s && scl_prev_q;
    assign bus_start = scl_s && scl_prev_q && sda_prev_q && !sda_s;
    assign bus_stop = scl_s && scl_prev_q && !sda_prev_q && sda_s;
    assign latch_fall = latch_prev_q && !latch_s;

    // ========================================================================
    // Byte receiver
    gamma_dac_pkg::rx_state_t state_q;
    logic [3:0] bit_cnt_q;
    logic [7:0] shift_q;
    logic ack_phase_q;
    logic [4:0] ptr_q;
    logic [7:0] hi_q;
    logic gc_pend_q;
    logic soft_rst_q;

    logic byte_done;
    logic ack_end;
    logic do_ack;
    logic word_wr;
    logic rst_all;
    logic rst_one;
    logic sw_update;
    logic [15:0] word;

    assign byte_done = scl_fall && !ack_phase_q && (bit_cnt_q == gamma_dac_pkg::ACK_SLOT);
    assign ack_end = scl_fall && ack_phase_q;
    assign word = {hi_q, shift_q};
    assign word_wr = byte_done && (state_q == gamma_dac_pkg::ST_DATA_LO);
    assign sw_update = word_wr && word[gamma_dac_pkg::SW_UPDATE_BIT];
    assign rst_all = byte_done && (state_q == gamma_dac_pkg::ST_POINTER) && chan_valid(shift_q)
        && (cmd_field(shift_q) == gamma_dac_pkg::CMD_RESET_ALL);
    assign rst_one = byte_done && (state_q == gamma_dac_pkg::ST_POINTER) && chan_valid(shift_q)
        && (cmd_field(shift_q) == gamma_dac_pkg::CMD_RESET_ONE);

    always_comb begin
        case (state_q)
            gamma_dac_pkg::ST_ADDR: begin
                do_ack = (shift_q == gamma_dac_pkg::DEV_ADDR_BYTE)
                    || (shift_q == gamma_dac_pkg::GC_ADDR_BYTE);
            end
            gamma_dac_pkg::ST_GC_DATA: do_ack = (shift_q == gamma_dac_pkg::GC_RESET_BYTE);
            gamma_dac_pkg::ST_POINTER: do_ack = chan_valid(shift_q);
            gamma_dac_pkg::ST_DATA_HI: do_ack = 1'b1;
            gamma_dac_pkg::ST_DATA_LO: do_ack = 1'b1;
            default: do_ack = 1'b0;
        endcase
    end

    // ========================================================================
    // Bit shifting and acknowledge slot
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            bit_cnt_q <= 4'h0;
            shift_q <= 8'h00;
            ack_phase_q <= 1'b0;
            sda_oe <= 1'b0;
        end else if (enable) begin
            if (soft_rst_q || bus_start || bus_stop) begin
                bit_cnt_q <= 4'h0;
                ack_phase_q <= 1'b0;
                sda_oe <= 1'b0;
            end else if (byte_done) begin
                ack_phase_q <= 1'b1;
                sda_oe <= do_ack;
            end else if (ack_end) begin
                ack_phase_q <= 1'b0;
                bit_cnt_q <= 4'h0;
                sda_oe <= 1'b0;
            end else if (scl_rise && !ack_phase_q && (bit_cnt_q != gamma_dac_pkg::ACK_SLOT)) begin
                shift_q <= {shift_q[6:0], sda_s};
                bit_cnt_q <= bit_cnt_q + 4'h1;
            end
        end
    end

    // ========================================================================
    // Open-drain line only ever pulls low
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            sda_out <= 1'b0;
        end else if (enable) begin
            sda_out <= 1'b0;
        end
    end

    // ========================================================================
    // Transaction sequencer
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= gamma_dac_pkg::ST_IDLE;
            ptr_q <= 5'h00;
            hi_q <= 8'h00;
            gc_pend_q <= 1'b0;
        end else if (enable) begin
            if (soft_rst_q) begin
                state_q <= gamma_dac_pkg::ST_IDLE;
                ptr_q <= 5'h00;
                hi_q <= 8'h00;
                gc_pend_q <= 1'b0;
            end else if (bus_start) begin
                state_q <= gamma_dac_pkg::ST_ADDR;
                gc_pend_q <= 1'b0;
            end else if (bus_stop) begin
                state_q <= gamma_dac_pkg::ST_IDLE;
                gc_pend_q <= 1'b0;
            end else if (byte_done) begin
                case (state_q)
                    gamma_dac_pkg::ST_ADDR: begin
                        if (shift_q == gamma_dac_pkg::DEV_ADDR_BYTE) begin
                            state_q <= gamma_dac_pkg::ST_POINTER;
                        end else if (shift_q == gamma_dac_pkg::GC_ADDR_BYTE) begin
                            state_q <= gamma_dac_pkg::ST_GC_DATA;
                        end else begin
                            state_q <= gamma_dac_pkg::ST_IGNORE;
                        end
                    end
                    gamma_dac_pkg::ST_GC_DATA: begin
                        // Reset waits for the ack slot to end so the ack is seen
                        gc_pend_q <= (shift_q == gamma_dac_pkg::GC_RESET_BYTE);
                        state_q <= gamma_dac_pkg::ST_IGNORE;
                    end
                    gamma_dac_pkg::ST_POINTER: begin
                        ptr_q <= shift_q[gamma_dac_pkg::CH_MSB:0];
                        state_q <= chan_valid(shift_q) ? gamma_dac_pkg::ST_DATA_HI
                            : gamma_dac_pkg::ST_IGNORE;
                    end
                    gamma_dac_pkg::ST_DATA_HI: begin
                        hi_q <= shift_q;
                        state_q <= gamma_dac_pkg::ST_DATA_LO;
                    end
                    gamma_dac_pkg::ST_DATA_LO: begin
                        // Streaming words advance to the next channel
                        if (ptr_q == 5'(gamma_dac_pkg::NUM_CH - 1)) begin
                            state_q <= gamma_dac_pkg::ST_IGNORE;
                        end else begin
                            ptr_q <= ptr_q + 5'h01;
                            state_q <= gamma_dac_pkg::ST_DATA_HI;
                        end
                    end
                    default: state_q <= state_q;
                endcase
            end
        end
    end

    // One-cycle pulse; the self-clear keeps one ack slot from firing it twice
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            soft_rst_q <= 1'b0;
        end else if (enable) begin
            soft_rst_q <= ack_end && gc_pend_q && !soft_rst_q;
        end
    end

    // ========================================================================
    // Channel register pairs
    logic [gamma_dac_pkg::CODE_W-1:0] store_q [gamma_dac_pkg::NUM_CH];

    genvar ch;
    generate
        // Channels 0 to 17 are gamma references, 18 and 19 common voltage
        for (ch = 0; ch < gamma_dac_pkg::NUM_CH; ch++) begin : g_chan
            logic hit;
            logic [gamma_dac_pkg::CODE_W-1:0] store_d;

            assign hit = (ptr_q == 5'(ch));

            always_comb begin
                if (rst_all || (rst_one && (shift_q[gamma_dac_pkg::CH_MSB:0] == 5'(ch)))) begin
                    store_d = gamma_dac_pkg::MIDPOINT_CODE;
                end else if (word_wr && hit) begin
                    store_d = word[gamma_dac_pkg::CODE_W-1:0];
                end else begin
                    store_d = store_q[ch];
                end
            end

            // Storage stage takes every bus write
            always_ff @(posedge clock or negedge rst_b) begin
                if (!rst_b) begin
                    store_q[ch] <= gamma_dac_pkg::MIDPOINT_CODE;
                end else if (enable) begin
                    if (soft_rst_q) begin
                        store_q[ch] <= gamma_dac_pkg::MIDPOINT_CODE;
                    end else begin
                        store_q[ch] <= store_d;
                    end
                end
            end

            // DAC stage drives the output code
            // A latch edge and a bus write in one cycle both take store_d, so none is lost
            always_ff @(posedge clock or negedge rst_b) begin
                if (!rst_b) begin
                    dac_code[ch] <= gamma_dac_pkg::MIDPOINT_CODE;
                end else if (enable) begin
                    if (soft_rst_q) begin
                        dac_code[ch] <= gamma_dac_pkg::MIDPOINT_CODE;
                    end else if (rst_all
                        || (rst_one && (shift_q[gamma_dac_pkg::CH_MSB:0] == 5'(ch)))) begin
                        dac_code[ch] <= gamma_dac_pkg::MIDPOINT_CODE;
                    end else if (latch_fall || sw_update) begin
                        dac_code[ch] <= store_d;
                    end else if (!latch_s && word_wr && hit) begin
                        dac_code[ch] <= store_d;
                    end
                    // Otherwise the latch is high or this channel has no bus write, and the output holds
                end
            end
        end
    endgenerate

endmodule // gamma_dac_latch_control

// >>> dv/gamma_dac_latch_control_properties.sv
// Port-level checks for the gamma DAC latch control block.
// Assumes the 100 MHz clock and a bus master no faster than 160 ns a bit.
`timescale 1ns/10ps

module gamma_dac_latch_control_properties (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic enable,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic output_latch_pin,
    input wire logic [gamma_dac_pkg::NUM_CH-1:0][gamma_dac_pkg::CODE_W-1:0] dac_code
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_b);

    // ========================================================================
    // Cycles since the last bus clock or latch falling edge
    logic [3:0] since_q;
    logic scl_q;
    logic latch_q;
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            since_q <= 4'hF;
            scl_q <= 1'b1;
            latch_q <= 1'b0;
        end else begin
            scl_q <= scl_in;
            latch_q <= output_latch_pin;
            if ((scl_q && !scl_in) || (latch_q && !output_latch_pin))
                since_q <= 4'h0;
            else if (since_q != 4'hF)
                since_q <= since_q + 4'h1;
        end
    end

    // ========================================================================
    // Assertions
    a_reset_mid: assert property ($rose(rst_b) |->
        dac_code == {gamma_dac_pkg::NUM_CH{gamma_dac_pkg::MIDPOINT_CODE}} && !sda_oe)
        else $error("codes not at midpoint after reset");
    a_drive_low_only: assert property (!sda_out)
        else $error("data line driven high");
    a_ack_scl_low: assert property ($rose(sda_oe) |-> !scl_in)
        else $error("ack began while bus clock high");
    a_ack_release: assert property ($fell(sda_oe) |-> !scl_in)
        else $error("ack ended while bus clock high");
    a_ack_holds: assert property ($rose(scl_in) && sda_oe |-> sda_oe [*6])
        else $error("ack dropped during ninth clock");
    a_ack_bounded: assert property ($rose(sda_oe) |-> ##[1:30] !sda_oe)
        else $error("ack held too long");
    a_freeze_enable: assert property (!enable |=> $stable(dac_code) && $stable(sda_oe))
        else $error("state moved while disabled");
    a_dac_cause: assert property ($changed(dac_code) |-> since_q < 4'hC)
        else $error("codes changed without a bus or latch edge");

    c_ack: cover property ($rose(sda_oe));
    c_soft_update: cover property ($changed(dac_code) && output_latch_pin);
    c_latch_fall: cover property ($fell(output_latch_pin));
endmodule // gamma_dac_latch_control_properties

bind gamma_dac_latch_control gamma_dac_latch_control_properties gamma_dac_latch_control_properties_i (
    .clock(clock), .rst_b(rst_b), .enable(enable), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .output_latch_pin(output_latch_pin),
    .dac_code(dac_code));

// >>> dv/gamma_bus_master.sv
// Behavioural two-wire bus master standing in for the timing controller.
// Assumes a pulled-up data line resolved by the bench; bus clock idles high.
`timescale 1ns/10ps

module gamma_bus_master (
    input wire logic clock,
    input wire logic sda_line,
    output logic scl,
    output logic sda
);
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end

    // Quarter bit of 40 ns, so one bit takes 160 ns
    task automatic q();
        repeat (4) @(negedge clock);
    endtask

    // Also serves as repeated start, entered with the bus clock low
    task automatic start();
        sda = 1'b1; q(); scl = 1'b1; q(); sda = 1'b0; q(); scl = 1'b0; q();
    endtask

    task automatic stop();
        sda = 1'b0; q(); scl = 1'b1; q(); sda = 1'b1; q();
    endtask

    // Most significant bit first, then releases the line for the ack slot
    task automatic send(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            sda = b[i]; q(); scl = 1'b1; q(); q(); scl = 1'b0; q();
        end
        sda = 1'b1; q(); scl = 1'b1; q();
        ack = !sda_line;
        q(); scl = 1'b0; q();
    endtask
endmodule // gamma_bus_master

// >>> dv/gamma_dac_latch_control_tb.sv
// Self-checking bench: bus master model drives writes, a watcher compares codes.
// Assumes the design package is compiled first.
`timescale 1ns/10ps

module gamma_dac_latch_control_tb;
    typedef logic [gamma_dac_pkg::NUM_CH-1:0][gamma_dac_pkg::CODE_W-1:0] bank_t;
    localparam bank_t MID = {gamma_dac_pkg::NUM_CH{gamma_dac_pkg::MIDPOINT_CODE}};
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic enable = 1'b1;
    logic latch = 1'b0;
    logic scl, sda_m, sda_out, sda_oe;
    bank_t dac_code, mdac = MID, mstor = MID, seen = MID, last = MID;
    bank_t exp_q[$];
    int fail_count = 0, comparisons = 0, seed = 32'h1eff;
    wire sda_line = sda_m & ~(sda_oe & ~sda_out);

    gamma_bus_master master (.clock(clock), .sda_line(sda_line), .scl(scl), .sda(sda_m));
    gamma_dac_latch_control gamma_dac_latch_control_i (.clock(clock), .rst_b(rst_b),
        .enable(enable), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
        .sda_oe(sda_oe), .output_latch_pin(latch), .dac_code(dac_code));

    initial forever #5 clock = ~clock;

    // ========================================================================
    // Checking
    task automatic check(input string what, input bank_t got, input bank_t exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic end_sim();
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic note();
        if (mdac !== last) begin
            exp_q.push_back(mdac);
            last = mdac;
        end
    endtask

    always @(negedge clock) begin
        if (rst_b && dac_code !== seen) begin
            if (exp_q.size() > 0) check("dac_code", dac_code, exp_q.pop_front());
            else check("dac_code", dac_code, seen);
            seen = dac_code;
        end
    end

    // ========================================================================
    // Bus helpers
    task automatic xfer(input logic [7:0] b, input logic exp);
        logic a;
        master.send(b, a);
        check("ack", bank_t'(a), bank_t'(exp));
    endtask

    task automatic open(input logic [7:0] ptr, input logic exp);
        master.start();
        xfer(gamma_dac_pkg::DEV_ADDR_BYTE, 1'b1);
        xfer(ptr, exp);
    endtask

    // Expected codes are queued before the low byte, since the update lands on it
    task automatic word(input int ch, input logic [15:0] w);
        xfer(w[15:8], 1'b1);
        mstor[ch] = w[9:0];
        if (!latch) mdac[ch] = mstor[ch];
        if (w[15]) mdac = mstor;
        note();
        xfer(w[7:0], 1'b1);
    endtask

    task automatic set_latch(input logic v);
        latch = v;
        if (!v) mdac = mstor;
        note();
        repeat (10) @(negedge clock);
    endtask

    // ========================================================================
    // Scenarios
    initial begin
        logic [15:0] w;
        logic [31:0] rnd;
        repeat (20) @(negedge clock);
        rst_b = 1'b1;
        check("reset_code", dac_code, MID);
        repeat (4) @(negedge clock);
        open(8'h00, 1'b1);
        for (int ch = 0; ch < gamma_dac_pkg::NUM_CH; ch++) begin
            rnd = $random(seed);
            w = {6'h00, rnd[9:0]};
            if (w[9:0] == mdac[ch]) w[9:0] = ~w[9:0];
            word(ch, w);
        end
        xfer(8'h5A, 1'b0);
        master.stop();
        enable = 1'b0;
        repeat (rnd[12:10] + 2) @(negedge clock);
        enable = 1'b1;
        set_latch(1'b1);
        open(8'h02, 1'b1);
        word(2, {6'h00, ~mstor[2]});
        word(3, {6'h00, ~mstor[3]});
        master.stop();
        set_latch(1'b0);
        set_latch(1'b1);
        open(8'h05, 1'b1);
        word(5, {6'h00, ~mstor[5]});
        word(6, {1'b1, 5'h00, ~mstor[6]});
        master.stop();
        master.start();
        xfer(gamma_dac_pkg::GC_ADDR_BYTE, 1'b1);
        mdac = MID;
        mstor = MID;
        note();
        xfer(gamma_dac_pkg::GC_RESET_BYTE, 1'b1);
        master.stop();
        set_latch(1'b0);
        master.start();
        xfer(gamma_dac_pkg::GC_ADDR_BYTE, 1'b1);
        xfer(8'h05, 1'b0);
        master.stop();
        master.start();
        xfer(8'h76, 1'b0);
        master.stop();
        open(8'h14, 1'b0);
        master.stop();
        open(8'h07, 1'b1);
        word(7, 16'h03C5);
        master.stop();
        mdac[7] = gamma_dac_pkg::MIDPOINT_CODE;
        mstor[7] = gamma_dac_pkg::MIDPOINT_CODE;
        note();
        open(8'h47, 1'b1);
        master.stop();
        open(8'h00, 1'b1);
        word(0, 16'h00A5);
        master.stop();
        mdac = MID;
        mstor = MID;
        note();
        open(8'h80, 1'b1);
        word(0, 16'h0311);
        master.stop();
        repeat (20) @(negedge clock);
        check("pending", bank_t'(exp_q.size()), bank_t'(0));
        end_sim();
    end

    initial begin
        #400000;
        fail_count++;
        end_sim();
    end
endmodule // gamma_dac_latch_control_tb
